// [rtl/pml_loader.sv]
`timescale 1ns/100ps

module pml_loader #(
  parameter int NPIN  = 16,
  parameter int DEPTH = 1024,
  parameter int NPAR  = 32,
  parameter int VW    = 16
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rst_n,
  input  wire logic              i_cmd_vld,
  input  wire pml_pkg::pml_cmd_s i_cmd,
  output logic                   o_cmd_rdy,
  input  wire logic              i_din_vld,
  input  wire logic [7:0]        i_din,
  output logic                   o_din_rdy,
  output logic                   o_dout_vld,
  output logic [7:0]             o_dout,
  output logic                   o_dout_last,
  input  wire logic              i_dout_rdy,
  output logic                   o_qval_vld,
  output logic [VW-1:0]          o_qval,
  output logic                   o_exec_err,
  output logic                   o_exec_warn,
  output logic                   o_done
);

  localparam int PW  = $clog2(NPIN);
  localparam int AW  = $clog2(DEPTH);
  localparam int RW  = $clog2(NPAR);
  localparam int SAW = pml_pkg::PML_SLOT_BITS + PW + RW;

  typedef enum logic [12:0] {
    ST_IDLE = 13'h0001, ST_SVRD = 13'h0002, ST_SVWR = 13'h0004, ST_PSET = 13'h0008,
    ST_PQRD = 13'h0010, ST_PQCM = 13'h0020, ST_LOAD = 13'h0040, ST_QRD  = 13'h0080,
    ST_QCAP = 13'h0100, ST_QOUT = 13'h0200, ST_FILL = 13'h0400, ST_CPRD = 13'h0800,
    ST_CPWR = 13'h1000
  } pml_state_e;

  pml_state_e        st_q;
  pml_pkg::pml_cmd_s c_q;
  logic [PW-1:0]     pin_q;
  logic [PW+RW-1:0]  idx_q;
  logic [15:0]       addr_q;
  logic [15:0]       addr2_q;
  logic [15:0]       cnt_q;
  logic [7:0]        sh_q;
  logic [7:0]        acc_q;
  logic [2:0]        bidx_q;
  logic [3:0]        nbits_q;
  logic              have_q;
  logic              desc_q;
  logic              diff_q;
  logic              ascii_q;
  logic              pw_en;
  logic [PW+AW-1:0]  pw_addr;
  logic              pw_data;
  logic [PW+AW-1:0]  pr_addr;
  logic              prd;
  logic              sw_en;
  logic [SAW-1:0]    sw_addr;
  logic [VW-1:0]     sw_data;
  logic [SAW-1:0]    sr_addr;
  logic [VW-1:0]     srd;
  logic              take_cmd;
  logic              take_din;
  logic              bad_char;

  // ==========================================================================
  // Argument checks at command acceptance
  // ==========================================================================
  function automatic logic run_bad(input logic [7:0] pin, input logic [15:0] addr, input logic [15:0] cnt);
    run_bad = (pin >= 8'(NPIN)) || (cnt == 16'h0000) || ({1'b0, addr} + {1'b0, cnt} > 17'(DEPTH));
  endfunction

  function automatic logic cmd_bad(input pml_pkg::pml_cmd_s c);
    case (c.op)
      pml_pkg::PML_OP_SAVE: cmd_bad = (c.slot < pml_pkg::PML_SLOT_MIN) || (c.slot > pml_pkg::PML_SLOT_MAX);
      pml_pkg::PML_OP_PSET,
      pml_pkg::PML_OP_PQRY: cmd_bad = (c.pin_last >= 8'(NPIN)) || (c.pin > c.pin_last) || (c.par >= 8'(NPAR));
      pml_pkg::PML_OP_COPY: cmd_bad = run_bad(c.pin, c.addr, c.count) || run_bad(c.pin2, c.addr2, c.count);
      pml_pkg::PML_OP_BLOAD, pml_pkg::PML_OP_BQRY, pml_pkg::PML_OP_FILL,
      pml_pkg::PML_OP_ALOAD, pml_pkg::PML_OP_AQRY: cmd_bad = run_bad(c.pin, c.addr, c.count);
      default: cmd_bad = 1'b1;
    endcase
  endfunction

  assign take_cmd = i_cmd_vld && o_cmd_rdy;
  assign take_din = i_din_vld && o_din_rdy;
  assign bad_char = ascii_q && (i_din != pml_pkg::PML_ASCII_ZERO) && (i_din != pml_pkg::PML_ASCII_ONE);

  // ==========================================================================
  // Memory port steering
  // ==========================================================================
  always_comb begin
    pw_en   = 1'b0;
    pw_data = sh_q[0];
    pw_addr = {c_q.pin[PW-1:0], addr_q[AW-1:0]};
    pr_addr = {c_q.pin[PW-1:0], addr_q[AW-1:0]};
    sw_en   = 1'b0;
    sw_addr = {{pml_pkg::PML_SLOT_BITS{1'b0}}, pin_q, c_q.par[RW-1:0]};
    sw_data = c_q.value;
    sr_addr = {{pml_pkg::PML_SLOT_BITS{1'b0}}, pin_q, c_q.par[RW-1:0]};
    case (st_q)
      ST_LOAD: pw_en = have_q;
      ST_FILL: begin
        pw_en   = 1'b1;
        pw_data = c_q.fill[bidx_q];
      end
      ST_CPRD: pr_addr = {c_q.pin2[PW-1:0], addr2_q[AW-1:0]};
      ST_CPWR: begin
        pw_en   = 1'b1;
        pw_data = prd;
      end
      ST_PSET: sw_en = 1'b1;
      ST_SVRD: sr_addr = {{pml_pkg::PML_SLOT_BITS{1'b0}}, idx_q};
      ST_SVWR: begin
        sw_en   = 1'b1;
        sw_addr = {c_q.slot[pml_pkg::PML_SLOT_BITS-1:0], idx_q};
        sw_data = srd;
      end
      default: ;
    endcase
  end

  pml_mem #(.W(1), .AW(PW + AW)) u_pat (
    .i_mclk  (i_mclk),
    .i_we    (pw_en),
    .i_waddr (pw_addr),
    .i_wdata (pw_data),
    .i_raddr (pr_addr),
    .o_rdata (prd)
  );

  // Slot 0 holds the live settings, slots 1 to 30 the saved copies.
  pml_mem #(.W(VW), .AW(SAW)) u_set (
    .i_mclk  (i_mclk),
    .i_we    (sw_en),
    .i_waddr (sw_addr),
    .i_wdata (sw_data),
    .i_raddr (sr_addr),
    .o_rdata (srd)
  );

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_q        <= ST_IDLE;
      c_q         <= '0;
      pin_q       <= '0;
      idx_q       <= '0;
      addr_q      <= 16'h0000;
      addr2_q     <= 16'h0000;
      cnt_q       <= 16'h0000;
      sh_q        <= 8'h00;
      acc_q       <= 8'h00;
      bidx_q      <= 3'h0;
      nbits_q     <= 4'h0;
      have_q      <= 1'b0;
      desc_q      <= 1'b0;
      diff_q      <= 1'b0;
      ascii_q     <= 1'b0;
      o_cmd_rdy   <= 1'b1;
      o_din_rdy   <= 1'b0;
      o_dout_vld  <= 1'b0;
      o_dout      <= pml_pkg::PML_DOUT_RST;
      o_dout_last <= 1'b0;
      o_qval_vld  <= 1'b0;
      o_qval      <= pml_pkg::PML_QVAL_RST;
      o_exec_err  <= 1'b0;
      o_exec_warn <= 1'b0;
      o_done      <= 1'b0;
    end else begin
      o_exec_err  <= 1'b0;
      o_exec_warn <= 1'b0;
      o_qval_vld  <= 1'b0;
      o_done      <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (take_cmd) begin
            c_q     <= i_cmd;
            pin_q   <= i_cmd.pin[PW-1:0];
            idx_q   <= '0;
            cnt_q   <= i_cmd.count;
            addr2_q <= i_cmd.addr2;
            bidx_q  <= 3'h0;
            nbits_q <= 4'h0;
            acc_q   <= 8'h00;
            have_q  <= 1'b0;
            diff_q  <= 1'b0;
            ascii_q <= (i_cmd.op == pml_pkg::PML_OP_ALOAD) || (i_cmd.op == pml_pkg::PML_OP_AQRY);
            // Same-pin copy toward higher addresses runs downward so no source bit is overwritten early.
            desc_q  <= (i_cmd.pin == i_cmd.pin2) && (i_cmd.addr > i_cmd.addr2);
            addr_q  <= i_cmd.addr;
            if ((i_cmd.op == pml_pkg::PML_OP_COPY) && (i_cmd.pin == i_cmd.pin2) && (i_cmd.addr > i_cmd.addr2)) begin
              addr_q  <= 16'(i_cmd.addr + i_cmd.count - 16'h0001);
              addr2_q <= 16'(i_cmd.addr2 + i_cmd.count - 16'h0001);
            end
            if (cmd_bad(i_cmd)) begin
              o_exec_err <= 1'b1;
              o_done     <= 1'b1;
            end else begin
              o_cmd_rdy <= 1'b0;
              case (i_cmd.op)
                pml_pkg::PML_OP_SAVE: st_q <= ST_SVRD;
                pml_pkg::PML_OP_PSET: st_q <= ST_PSET;
                pml_pkg::PML_OP_PQRY: st_q <= ST_PQRD;
                pml_pkg::PML_OP_FILL: st_q <= ST_FILL;
                pml_pkg::PML_OP_COPY: st_q <= ST_CPRD;
                pml_pkg::PML_OP_BQRY,
                pml_pkg::PML_OP_AQRY: st_q <= ST_QRD;
                default: begin
                  st_q      <= ST_LOAD;
                  o_din_rdy <= 1'b1;
                end
              endcase
            end
          end
        end
        ST_SVRD: st_q <= ST_SVWR;
        ST_SVWR: begin
          idx_q <= idx_q + 1'b1;
          if (idx_q == '1) begin
            st_q <= ST_IDLE;
          end else begin
            st_q <= ST_SVRD;
          end
        end
        ST_PSET: begin
          pin_q <= pin_q + 1'b1;
          if (pin_q == c_q.pin_last[PW-1:0]) begin
            st_q <= ST_IDLE;
          end
        end
        ST_PQRD: st_q <= ST_PQCM;
        ST_PQCM: begin
          if (pin_q == c_q.pin[PW-1:0]) begin
            o_qval <= srd;
          end else if (srd != o_qval) begin
            diff_q <= 1'b1;
          end
          pin_q <= pin_q + 1'b1;
          st_q  <= ST_PQRD;
          if (pin_q == c_q.pin_last[PW-1:0]) begin
            st_q        <= ST_IDLE;
            o_qval_vld  <= 1'b1;
            o_exec_warn <= diff_q || ((pin_q != c_q.pin[PW-1:0]) && (srd != o_qval));
          end
        end
        ST_LOAD: begin
          if (take_din) begin
            o_din_rdy <= 1'b0;
            if (bad_char) begin
              o_exec_err <= 1'b1;
              st_q       <= ST_IDLE;
            end else begin
              sh_q    <= ascii_q ? {7'h00, i_din[0]} : i_din;
              nbits_q <= ascii_q ? 4'h1 : pml_pkg::PML_BYTE_BITS;
              have_q  <= 1'b1;
            end
          end else if (have_q) begin
            sh_q    <= sh_q >> 1;
            nbits_q <= nbits_q - 4'h1;
            addr_q  <= addr_q + 16'h0001;
            cnt_q   <= cnt_q - 16'h0001;
            if (cnt_q == 16'h0001) begin
              st_q   <= ST_IDLE;
              have_q <= 1'b0;
            end else if (nbits_q == 4'h1) begin
              have_q    <= 1'b0;
              o_din_rdy <= 1'b1;
            end
          end
        end
        ST_QRD: st_q <= ST_QCAP;
        ST_QCAP: begin
          acc_q  <= acc_q | (8'(prd) << bidx_q);
          bidx_q <= bidx_q + 3'h1;
          addr_q <= addr_q + 16'h0001;
          cnt_q  <= cnt_q - 16'h0001;
          st_q   <= ST_QRD;
          if (ascii_q || (bidx_q == 3'h7) || (cnt_q == 16'h0001)) begin
            o_dout      <= ascii_q ? (pml_pkg::PML_ASCII_ZERO | 8'(prd)) : (acc_q | (8'(prd) << bidx_q));
            o_dout_vld  <= 1'b1;
            o_dout_last <= (cnt_q == 16'h0001);
            st_q        <= ST_QOUT;
          end
        end
        ST_QOUT: begin
          if (i_dout_rdy) begin
            o_dout_vld  <= 1'b0;
            o_dout_last <= 1'b0;
            acc_q       <= 8'h00;
            bidx_q      <= 3'h0;
            st_q        <= o_dout_last ? ST_IDLE : ST_QRD;
          end
        end
        ST_FILL: begin
          bidx_q <= bidx_q + 3'h1;
          addr_q <= addr_q + 16'h0001;
          cnt_q  <= cnt_q - 16'h0001;
          if (cnt_q == 16'h0001) begin
            st_q <= ST_IDLE;
          end
        end
        ST_CPRD: st_q <= ST_CPWR;
        ST_CPWR: begin
          addr_q  <= desc_q ? addr_q - 16'h0001 : addr_q + 16'h0001;
          addr2_q <= desc_q ? addr2_q - 16'h0001 : addr2_q + 16'h0001;
          cnt_q   <= cnt_q - 16'h0001;
          st_q    <= (cnt_q == 16'h0001) ? ST_IDLE : ST_CPRD;
        end
        default: st_q <= ST_IDLE;
      endcase
      if ((st_q != ST_IDLE) && (st_q != ST_QOUT)) begin
        if ((st_q == ST_IDLE) || ((st_q == ST_LOAD) && take_din && bad_char) ||
            ((st_q == ST_SVWR) && (idx_q == '1)) ||
            ((st_q == ST_PSET) && (pin_q == c_q.pin_last[PW-1:0])) ||
            ((st_q == ST_PQCM) && (pin_q == c_q.pin_last[PW-1:0])) ||
            ((st_q == ST_LOAD) && !take_din && have_q && (cnt_q == 16'h0001)) ||
            (((st_q == ST_FILL) || (st_q == ST_CPWR)) && (cnt_q == 16'h0001))) begin
          o_cmd_rdy <= 1'b1;
          o_done    <= 1'b1;
        end
      end else if ((st_q == ST_QOUT) && i_dout_rdy && o_dout_last) begin
        o_cmd_rdy <= 1'b1;
        o_done    <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_bin_byte_taken;
    (st_q == ST_LOAD) && take_din && !ascii_q && (cnt_q > 16'h0001);
  endsequence

  a_save_refused: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    take_cmd && (i_cmd.op == pml_pkg::PML_OP_SAVE) && ((i_cmd.slot == 8'h00) || (i_cmd.slot > 8'h1E))
    |=> o_exec_err && (st_q == ST_IDLE)) else $error("bad save slot not refused");
  a_save_slot_used: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    sw_en && (st_q == ST_SVWR) |-> (sw_addr[SAW-1 -: 5] >= 5'h01) && (sw_addr[SAW-1 -: 5] <= 5'h1E))
    else $error("save wrote outside slots 1 to 30");
  a_load_lsb_first: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    s_bin_byte_taken ##0 !bad_char |=> pw_en && (pw_data == $past(i_din[0])) ##1 pw_en && (pw_data == $past(i_din[1], 2)))
    else $error("binary byte not unpacked lsb first");
  a_ascii_reject: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (st_q == ST_LOAD) && take_din && bad_char |=> o_exec_err && o_done && o_cmd_rdy) else $error("non-binary digit accepted");
  a_fill_wraps: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (st_q == ST_FILL) && (bidx_q == 3'h7) && (cnt_q != 16'h0001) |=> pw_data == c_q.fill[0])
    else $error("fill byte did not repeat from lsb");
  a_warn_with_value: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_exec_warn |-> o_qval_vld) else $error("warning raised without query answer");
  a_copy_pairs: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (st_q == ST_CPRD) |=> (st_q == ST_CPWR) && pw_en) else $error("copy read not followed by write");
  a_dout_holds: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_dout_vld && !i_dout_rdy |=> o_dout_vld && $stable(o_dout)) else $error("query byte dropped before taken");

endmodule

// [rtl/pml_pkg.sv]
package pml_pkg;

  // ==========================================================================
  // Command encodings
  // ==========================================================================
  typedef enum logic [3:0] {
    PML_OP_NONE  = 4'h0,
    PML_OP_SAVE  = 4'h1,
    PML_OP_PSET  = 4'h2,
    PML_OP_PQRY  = 4'h3,
    PML_OP_BLOAD = 4'h4,
    PML_OP_BQRY  = 4'h5,
    PML_OP_FILL  = 4'h6,
    PML_OP_ALOAD = 4'h7,
    PML_OP_AQRY  = 4'h8,
    PML_OP_COPY  = 4'h9
  } pml_op_e;

  // ==========================================================================
  // Decoded command, handed over by the command parser
  // ==========================================================================
  typedef struct packed {
    pml_op_e     op;
    logic [7:0]  pin;
    logic [7:0]  pin_last;
    logic [15:0] addr;
    logic [15:0] count;
    logic [7:0]  pin2;
    logic [15:0] addr2;
    logic [7:0]  slot;
    logic [7:0]  par;
    logic [15:0] value;
    logic [7:0]  fill;
  } pml_cmd_s;

  // ==========================================================================
  // Constants
  // ==========================================================================
  localparam logic [7:0]  PML_SLOT_MIN    = 8'h01;
  localparam logic [7:0]  PML_SLOT_MAX    = 8'h1E;
  localparam int          PML_SLOT_BITS   = 5;
  localparam logic [3:0]  PML_BYTE_BITS   = 4'h8;
  localparam logic [7:0]  PML_ASCII_ZERO  = 8'h30;
  localparam logic [7:0]  PML_ASCII_ONE   = 8'h31;
  localparam logic [7:0]  PML_PAR_VIEW    = 8'h15;
  localparam logic [15:0] PML_VIEW_GROUP  = 16'h0000;
  localparam logic [15:0] PML_VIEW_CHAN   = 16'h0001;
  localparam logic [7:0]  PML_DOUT_RST    = 8'h00;
  localparam logic [15:0] PML_QVAL_RST    = 16'h0000;

endpackage

// [rtl/pml_mem.sv]
`timescale 1ns/100ps

module pml_mem #(
  parameter int W  = 1,
  parameter int AW = 10
) (
  input  wire logic          i_mclk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [W-1:0]  i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [W-1:0]  o_rdata
);

  logic [W-1:0] mem [0:(1<<AW)-1];

  // ==========================================================================
  // One write port, one registered read port
  // ==========================================================================
  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    o_rdata <= mem[i_raddr];
  end

endmodule

// [dv/pml_ctl_model.sv]
`timescale 1ns/100ps

module pml_ctl_model (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_din_rdy,
  input  wire logic       i_dout_vld,
  input  wire logic [7:0] i_dout,
  input  wire logic       i_dout_last,
  output logic            o_din_vld,
  output logic [7:0]      o_din,
  output logic            o_dout_rdy
);
  logic [7:0] tx_q [$];
  logic [8:0] rx_q [$];

  initial begin
    o_din_vld = 1'b0;
    o_din = 8'h00;
    o_dout_rdy = 1'b0;
  end

  // ==========================================================================
  // Data source and sink
  // ==========================================================================
  // Block framing is stripped upstream, so bytes arrive bare and in address order.
  // An idle data line toggles so that a design reading it out of turn is caught.
  always @(posedge i_mclk) begin
    if (o_din_vld && i_din_rdy) begin
      void'(tx_q.pop_front());
    end
    if (!i_rst_n) begin
      o_din_vld <= 1'b0;
    end else if (tx_q.size() != 0) begin
      o_din_vld <= 1'b1;
      o_din <= tx_q[0];
    end else begin
      o_din_vld <= 1'b0;
      o_din <= ~o_din;
    end
    // The consumer stalls at random to prove that query bytes are held.
    o_dout_rdy <= i_rst_n && ($urandom_range(3) != 0);
    if (i_dout_vld && o_dout_rdy) begin
      rx_q.push_back({i_dout_last, i_dout});
    end
  end
endmodule

// [dv/tb.sv]
`timescale 1ns/100ps

module tb;
  logic              i_mclk;
  logic              i_rst_n = 1'b0;
  logic              i_cmd_vld = 1'b0;
  pml_pkg::pml_cmd_s i_cmd = '0;
  logic              i_din_vld, i_dout_rdy, o_cmd_rdy, o_din_rdy, o_dout_vld, o_dout_last;
  logic              o_qval_vld, o_exec_err, o_exec_warn, o_done, g_err, g_warn, g_qv;
  logic [7:0]        i_din, o_dout;
  logic [15:0]       o_qval, g_q;
  int                fail_count = 0;
  int                n_checks = 0;
  logic              mem [4][64];
  pml_pkg::pml_cmd_s c;

  pml_loader #(.NPIN(4), .DEPTH(64), .NPAR(32), .VW(16)) i_dut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cmd_vld(i_cmd_vld), .i_cmd(i_cmd), .o_cmd_rdy(o_cmd_rdy),
    .i_din_vld(i_din_vld), .i_din(i_din), .o_din_rdy(o_din_rdy), .o_dout_vld(o_dout_vld),
    .o_dout(o_dout), .o_dout_last(o_dout_last), .i_dout_rdy(i_dout_rdy), .o_qval_vld(o_qval_vld),
    .o_qval(o_qval), .o_exec_err(o_exec_err), .o_exec_warn(o_exec_warn), .o_done(o_done));

  pml_ctl_model i_ctl (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_din_rdy(o_din_rdy), .i_dout_vld(o_dout_vld),
    .i_dout(o_dout), .i_dout_last(o_dout_last), .o_din_vld(i_din_vld), .o_din(i_din),
    .o_dout_rdy(i_dout_rdy));

  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic pml_pkg::pml_cmd_s mk(input pml_pkg::pml_op_e op, input logic [7:0] pin,
      input logic [15:0] ad, input logic [15:0] n, input logic [7:0] x, input logic [15:0] y);
    mk = '0;
    mk.op = op;
    mk.pin = pin;
    mk.pin_last = pin;
    mk.addr = ad;
    mk.count = n;
    mk.pin2 = x;
    mk.addr2 = y;
    mk.slot = x;
    mk.par = x;
    mk.value = y;
    mk.fill = x;
  endfunction

  // Expected query element j: a packed byte, or one digit character, with the last flag on top.
  function automatic logic [8:0] expel(input int pin, input int a, input int n, input int j, input bit asc);
    expel = 9'h000;
    if (asc) begin
      expel[7:0] = mem[pin][a+j] ? 8'h31 : 8'h30;
    end else begin
      for (int b = 0; b < 8; b++) begin
        if (8 * j + b < n) expel[b] = mem[pin][a+8*j+b];
      end
    end
    expel[8] = asc ? (j == n - 1) : (j == (n + 7) / 8 - 1);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic run(input pml_pkg::pml_cmd_s cc);
    int k;
    i_ctl.rx_q.delete();
    @(posedge i_mclk);
    i_cmd <= cc;
    i_cmd_vld <= 1'b1;
    k = 0;
    do begin
      @(posedge i_mclk);
      k++;
    end while (o_cmd_rdy !== 1'b1 && k < 50);
    i_cmd_vld <= 1'b0;
    {g_err, g_warn, g_qv} = 3'b000;
    k = 0;
    // Flags are gathered over the whole command, though the answer and the flags come in the same cycle as the finish pulse.
    // A refused command finishes at the edge that takes it, so the first look comes before any wait.
    do begin
      #1;
      k++;
      g_err = g_err | (o_exec_err === 1'b1);
      g_warn = g_warn | (o_exec_warn === 1'b1);
      if (o_qval_vld === 1'b1) g_q = o_qval;
      g_qv = g_qv | (o_qval_vld === 1'b1);
      if (o_done !== 1'b1) @(posedge i_mclk);
    end while (o_done !== 1'b1 && k < 3000);
    chk(16'(o_done), 16'h0001, "command finish");
    i_ctl.tx_q.delete();
  endtask

  task automatic q(input logic [7:0] pin, input logic [15:0] a, input logic [15:0] n, input bit asc);
    int nb;
    nb = asc ? n : (n + 7) / 8;
    run(mk(asc ? pml_pkg::PML_OP_AQRY : pml_pkg::PML_OP_BQRY, pin, a, n, 8'h00, 16'h0000));
    chk(16'(i_ctl.rx_q.size()), 16'(nb), "query length");
    for (int j = 0; j < nb && j < i_ctl.rx_q.size(); j++) begin
      chk(16'(i_ctl.rx_q[j]), 16'(expel(pin, a, n, j, asc)), "query element");
    end
  endtask

  task automatic bload(input logic [7:0] pin, input logic [15:0] a, input logic [15:0] n,
      input bit rnd, input logic [15:0] fx);
    logic [7:0] by;
    for (int i = 0; i < (n + 7) / 8; i++) begin
      by = rnd ? 8'($urandom) : fx[8*i+:8];
      i_ctl.tx_q.push_back(by);
      for (int k = 0; k < 8; k++) if (8 * i + k < n) mem[pin][a+8*i+k] = by[k];
    end
    run(mk(pml_pkg::PML_OP_BLOAD, pin, a, n, 8'h00, 16'h0000));
    chk(16'(g_err), 16'h0000, "binary load refused");
  endtask

  task automatic fill(input logic [7:0] pin, input logic [15:0] a, input logic [15:0] n, input logic [7:0] f);
    for (int i = 0; i < n; i++) mem[pin][a+i] = f[i%8];
    run(mk(pml_pkg::PML_OP_FILL, pin, a, n, f, 16'h0000));
    chk(16'(g_err), 16'h0000, "fill refused");
  endtask

  task automatic aload(input logic [7:0] pin, input logic [15:0] a, input logic [15:0] n, input int bad);
    logic r;
    for (int i = 0; i < n; i++) begin
      if (i == bad) begin
        i_ctl.tx_q.push_back(8'h32);
        break;
      end
      r = 1'($urandom);
      i_ctl.tx_q.push_back(r ? 8'h31 : 8'h30);
      mem[pin][a+i] = r;
    end
    run(mk(pml_pkg::PML_OP_ALOAD, pin, a, n, 8'h00, 16'h0000));
    chk(16'(g_err), 16'(bad < n), "digit load error flag");
  endtask

  task automatic copy(input logic [7:0] dp, input logic [15:0] da, input logic [7:0] sp,
      input logic [15:0] sa, input logic [15:0] n);
    logic t [64];
    for (int i = 0; i < n; i++) t[i] = mem[sp][sa+i];
    for (int i = 0; i < n; i++) mem[dp][da+i] = t[i];
    run(mk(pml_pkg::PML_OP_COPY, dp, da, n, sp, sa));
    chk(16'(g_err), 16'h0000, "copy refused");
  endtask

  task automatic param(input pml_pkg::pml_op_e op, input logic [7:0] p0, input logic [7:0] p1,
      input logic [7:0] par, input logic [15:0] v);
    c = mk(op, p0, 16'h0000, 16'h0001, par, v);
    c.pin_last = p1;
    run(c);
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #400000;
    fail_count++;
    $display("CHECK FAILED %0t run did not finish", $time);
    results();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic [15:0] v;
    void'($urandom(96180));
    repeat (8) @(posedge i_mclk);
    chk(16'({o_cmd_rdy, o_dout_vld, o_done, o_exec_err}), 16'h0008, "reset outputs");
    i_rst_n <= 1'b1;
    for (int p = 0; p < 4; p++) fill(8'(p), 16'h0000, 16'h0040, 8'h00);
    bload(8'h01, 16'h0000, 16'h0010, 1'b0, 16'h3847);
    q(8'h01, 16'h0000, 16'h0010, 1'b1);
    q(8'h01, 16'h0000, 16'h000C, 1'b0);
    for (int i = 0; i < 4; i++) begin
      bload(8'($urandom_range(3)), 16'($urandom_range(39)), 16'($urandom_range(24, 1)), 1'b1, 16'h0000);
      q(8'h00, 16'h0000, 16'h0040, 1'b0);
      q(8'h02, 16'h0007, 16'h0021, 1'b0);
    end
    fill(8'h02, 16'h0003, 16'h0005, 8'hFF);
    fill(8'h02, 16'h000A, 16'h0014, 8'($urandom));
    q(8'h02, 16'h0000, 16'h0028, 1'b1);
    aload(8'h00, 16'h0005, 16'h0008, 99);
    aload(8'h00, 16'h0030, 16'h0004, 2);
    q(8'h00, 16'h0000, 16'h0040, 1'b1);
    copy(8'h03, 16'h0004, 8'h01, 16'h0000, 16'h0008);
    copy(8'h01, 16'h0002, 8'h01, 16'h0000, 16'h000A);
    copy(8'h02, 16'h0000, 8'h02, 16'h0003, 16'h000C);
    q(8'h03, 16'h0000, 16'h0010, 1'b0);
    q(8'h01, 16'h0000, 16'h0010, 1'b0);
    q(8'h02, 16'h0000, 16'h0010, 1'b0);
    // Refused commands: slot edges, zero count, bad pin, overrun, no operation.
    run(mk(pml_pkg::PML_OP_SAVE, 8'h00, 16'h0000, 16'h0001, 8'h00, 16'h0000));
    chk(16'(g_err), 16'h0001, "slot 0 accepted");
    run(mk(pml_pkg::PML_OP_SAVE, 8'h00, 16'h0000, 16'h0001, 8'h1F, 16'h0000));
    chk(16'(g_err), 16'h0001, "slot 31 accepted");
    run(mk(pml_pkg::PML_OP_FILL, 8'h00, 16'h0000, 16'h0000, 8'hFF, 16'h0000));
    chk(16'(g_err), 16'h0001, "zero count accepted");
    run(mk(pml_pkg::PML_OP_BQRY, 8'h04, 16'h0000, 16'h0008, 8'h00, 16'h0000));
    chk(16'(g_err), 16'h0001, "bad pin accepted");
    run(mk(pml_pkg::PML_OP_COPY, 8'h00, 16'h003C, 16'h0005, 8'h01, 16'h0000));
    chk(16'(g_err), 16'h0001, "overrun accepted");
    run(mk(pml_pkg::PML_OP_NONE, 8'h00, 16'h0000, 16'h0001, 8'h00, 16'h0000));
    chk(16'(g_err), 16'h0001, "empty op accepted");
    run(mk(pml_pkg::PML_OP_SAVE, 8'h00, 16'h0000, 16'h0001, 8'h01, 16'h0000));
    chk(16'(g_err), 16'h0000, "slot 1 refused");
    run(mk(pml_pkg::PML_OP_SAVE, 8'h00, 16'h0000, 16'h0001, 8'h1E, 16'h0000));
    chk(16'(g_err), 16'h0000, "slot 30 refused");
    q(8'h01, 16'h0000, 16'h0010, 1'b0);
    v = 16'($urandom);
    param(pml_pkg::PML_OP_PSET, 8'h00, 8'h03, 8'h03, v);
    param(pml_pkg::PML_OP_PQRY, 8'h01, 8'h03, 8'h03, 16'h0000);
    chk(g_q, v, "bus value");
    chk(16'({g_qv, g_warn}), 16'h0002, "uniform bus warned");
    param(pml_pkg::PML_OP_PSET, 8'h02, 8'h02, 8'h03, ~v);
    param(pml_pkg::PML_OP_PQRY, 8'h01, 8'h03, 8'h03, 16'h0000);
    chk(g_q, v, "first pin value");
    chk(16'({g_qv, g_warn}), 16'h0003, "mixed bus not warned");
    param(pml_pkg::PML_OP_PQRY, 8'h02, 8'h02, 8'h03, 16'h0000);
    chk(g_q, ~v, "single pin value");
    // Settings memory is not cleared by reset, so every view is given a known value first.
    param(pml_pkg::PML_OP_PSET, 8'h00, 8'h03, pml_pkg::PML_PAR_VIEW, pml_pkg::PML_VIEW_GROUP);
    param(pml_pkg::PML_OP_PSET, 8'h01, 8'h01, pml_pkg::PML_PAR_VIEW, pml_pkg::PML_VIEW_CHAN);
    param(pml_pkg::PML_OP_PQRY, 8'h01, 8'h01, pml_pkg::PML_PAR_VIEW, 16'h0000);
    chk(g_q, pml_pkg::PML_VIEW_CHAN, "view value");
    param(pml_pkg::PML_OP_PQRY, 8'h00, 8'h00, pml_pkg::PML_PAR_VIEW, 16'h0000);
    chk(g_q, pml_pkg::PML_VIEW_GROUP, "view of other pin");
    param(pml_pkg::PML_OP_PQRY, 8'h02, 8'h01, 8'h03, 16'h0000);
    chk(16'(g_err), 16'h0001, "reversed range accepted");
    results();
  end
endmodule
